// >>> hdl/spw_params.svh
// Constants for the condition status and write protect block.
// Included by the block's modules and the bench; holds definitions only.
`ifndef SPW_PARAMS_SVH
`define SPW_PARAMS_SVH

// Command numbers
`define SPW_CMD_QUERY      8'h00
`define SPW_CMD_CLEAR      8'h01
`define SPW_CMD_FIXED      8'h1B
`define SPW_CMD_PROTECT    8'h21
`define SPW_CMD_STORE      8'h16

// Negative acknowledge reason codes
`define SPW_NAK_LOCKOUT    8'h09
`define SPW_NAK_BUSY       8'h01

// Condition status word bit positions
`define SPW_BIT_HOST_DONE  15
`define SPW_BIT_NV_ERR     14
`define SPW_BIT_PROG_DONE  13
`define SPW_BIT_CMD_ERR    12
`define SPW_BIT_EXIT_MET   11
`define SPW_BIT_VOLTAGE    10
`define SPW_BIT_HOLD_ERR   9
`define SPW_BIT_MOVE_ERR   8
`define SPW_BIT_RX_OVF     7
`define SPW_BIT_CHECK_MET  6
`define SPW_BIT_TOO_LONG   5
`define SPW_BIT_FRAMING    4
`define SPW_BIT_KILL       3
`define SPW_BIT_SOFT_LIM   2
`define SPW_BIT_RX_CKS     1
`define SPW_BIT_ABORT_PKT  0

// Reset values and address limits
`define SPW_STATUS_RST     16'h0000
`define SPW_FIRST_WR_RST   16'h0000
`define SPW_LOCK_RST       16'h0000
`define SPW_PROT_ALL       16'hFFFF
`define SPW_FACTORY_BASE   16'hF800

`endif

// >>> hdl/spw_pkg.sv
// Types shared by the condition status and write protect block.
// Needs no other file.
package spw_pkg;

  typedef enum logic [1:0]
  {
    SPW_RESP_ACK  = 2'b00,
    SPW_RESP_WORD = 2'b01,
    SPW_RESP_NAK  = 2'b10
  } spw_resp_kind_t;

  typedef enum logic [1:0]
  {
    SPW_WR_PLAIN = 2'b00,
    SPW_WR_SAVE  = 2'b01,
    SPW_WR_STORE = 2'b10
  } spw_wr_kind_t;

endpackage

// >>> hdl/spw_cond_status.sv
// Latched, double buffered condition status word.
// Assumes one read or one clear strobe per cycle from the command logic.
`timescale 1ns/1ps
`include "spw_params.svh"

module spw_cond_status
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Events and commands
  input  wire logic [15:0] set_bits,
  input  wire logic        read_strobe,
  input  wire logic        clear_strobe,
  input  wire logic [15:0] clear_mask,
  // State
  output logic      [15:0] live
);

  logic [15:0] shown;
  logic [15:0] next_live;
  logic [15:0] next_shown;
  wire  [15:0] clr_eff = clear_strobe ? (clear_mask & shown) : 16'h0000;

  // Only bits already reported can be cleared; set wins over clear
  assign next_live  = (live & ~clr_eff) | set_bits;
  assign next_shown = read_strobe ? live :
                      (clear_strobe ? (shown & ~clear_mask) : shown);

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      live  <= `SPW_STATUS_RST;
      shown <= `SPW_STATUS_RST;
    end
    else
    begin
      live  <= next_live;
      shown <= next_shown;
    end
  end

endmodule

// >>> hdl/spw_nv_guard.sv
// Address check for writes into non-volatile memory.
// Purely combinational; protection state is held by the caller.
`timescale 1ns/1ps
`include "spw_params.svh"

module spw_nv_guard
(
  // Address under test
  input  wire logic [15:0] addr,
  // Protection state
  input  wire logic [15:0] first_wr,
  input  wire logic        factory_on,
  input  wire logic [15:0] factory_base,
  // Verdict
  output logic             protect_hit
);

  function automatic logic in_user_lock(input logic [15:0] a, input logic [15:0] lim);
    in_user_lock = (lim == `SPW_PROT_ALL) || (a < lim);
  endfunction

  // Limit of all ones locks every address, not just those below it
  assign protect_hit = in_user_lock(addr, first_wr)
                     | (factory_on && (addr >= factory_base));

endmodule

// >>> hdl/spw_status_poll.sv
// Top of the condition status and write protect command handler.
// Expects decoded command packets, condition events and memory write requests
// from the surrounding controller; replies go back to its serial framer.
`timescale 1ns/1ps
`include "spw_params.svh"

// Overview of operation
// - Status queries are answered at any time without touching motion logic.
// - Query answers acknowledge when no bit set, else the status word.
// - Status bits latch on their condition and hold until cleared.
// - Only already reported bits clear; later conditions survive to next query.
// - Command zero, or a packet with no command number, is a query.
// - Fixed-format query always returns the status word, even when zero.
// - Bit 15 host command done; bit 13 program buffer finished.
// - Bit 14 non-volatile memory checksum error.
// - Bit 12 command failed: bad parameters or unsupported.
// - Bit 7 receive overflow; bit 5 packet over 31 bytes; bit 4 framing.
// - Bit 1 bad checksum in checksummed protocols; bit 0 aborted packet.
// - Bit 11 exit condition; bit 9 holding error; bit 8 moving error.
// - Bit 10 voltage fault; bit 6 status check met; bit 2 soft limit.
// - Bit 3 latches on kill shutdown; clear works while kill persists.
// - Protect command takes lockout code and first writable address.
// - First writable address zero with a nonzero lockout code removes protection and clears lockout code.
// - First writable address 65535 protects all user memory.
// - Writes below the first writable address are blocked, register saves too.
// - Factory block protected; both parameters zero only enables that.
// - Protect command while busy gets a busy refusal and does nothing.
// - Lockout mismatch or store into protected space refused with code 9.
// - Register save into protected space sets bits 14, 12 and ends program.
// - Clear command one with a mask clears only masked bits.
module spw_status_poll
#(
  parameter logic [15:0] FACTORY_BASE    = `SPW_FACTORY_BASE,
  parameter bit          FACTORY_PROT_ON = 1'b1
)
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Decoded command packet
  input  wire logic        cmd_valid,
  input  wire logic        cmd_has_code,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [15:0] cmd_arg0,
  input  wire logic [15:0] cmd_arg1,
  input  wire logic        device_busy,
  // Condition events, one-cycle pulses unless noted
  input  wire logic        ev_host_cmd_done,
  input  wire logic        ev_nv_checksum,
  input  wire logic        ev_prog_done,
  input  wire logic        ev_cmd_error,
  input  wire logic        ev_exit_met,
  input  wire logic        ev_voltage,
  input  wire logic        ev_hold_error,
  input  wire logic        ev_move_error,
  input  wire logic        ev_rx_overflow,
  input  wire logic        ev_check_met,
  input  wire logic        ev_too_long,
  input  wire logic        ev_framing,
  input  wire logic        kill_active,
  input  wire logic        ev_soft_limit,
  input  wire logic        ev_rx_checksum,
  input  wire logic        proto_checksummed,
  input  wire logic        ev_aborted_pkt,
  // Non-volatile write request
  input  wire logic        nv_wr_req,
  input  wire logic [15:0] nv_wr_addr,
  input  wire logic [1:0]  nv_wr_kind,
  // Reply to the serial framer
  output logic             resp_valid,
  output logic [1:0]       resp_kind,
  output logic [7:0]       resp_cmd,
  output logic [15:0]      resp_word,
  output logic [7:0]       resp_nak_code,
  // Write verdict
  output logic             nv_wr_grant,
  output logic             nv_wr_denied,
  output logic             prog_abort,
  // State
  output logic [15:0]      condition_status_word,
  output logic [15:0]      first_writable,
  output logic             factory_protected
);

  logic [15:0] lock_code;
  logic        kill_seen;
  logic        store_nak_pend;
  logic [15:0] live;
  logic        prot_hit;

  // Command decode
  wire is_query   = cmd_valid && (!cmd_has_code || cmd_code == `SPW_CMD_QUERY);
  wire is_fixed   = cmd_valid && cmd_has_code && cmd_code == `SPW_CMD_FIXED;
  wire is_clear   = cmd_valid && cmd_has_code && cmd_code == `SPW_CMD_CLEAR;
  wire is_protect = cmd_valid && cmd_has_code && cmd_code == `SPW_CMD_PROTECT;
  wire cmd_answer = is_query || is_fixed || is_clear || is_protect;

  // Protect command outcome
  wire both_zero  = (cmd_arg0 == 16'h0000) && (cmd_arg1 == 16'h0000);
  wire prot_on    = (first_writable != 16'h0000);
  wire pup_busy   = is_protect && device_busy;
  wire pup_bad    = is_protect && !device_busy && !both_zero
                    && prot_on && (cmd_arg0 != lock_code);
  wire pup_ok     = is_protect && !device_busy && !pup_bad;
  wire pup_set    = pup_ok && !both_zero;

  // Write check
  wire wr_blocked = nv_wr_req && prot_hit;
  wire save_fail  = wr_blocked && nv_wr_kind == spw_pkg::SPW_WR_SAVE;
  wire store_fail = wr_blocked && nv_wr_kind == spw_pkg::SPW_WR_STORE;

  // Kill is a level; only its onset sets the bit so a clear sticks
  wire kill_rise  = kill_active && !kill_seen;

  wire [15:0] ev_bits;
  assign ev_bits[`SPW_BIT_HOST_DONE] = ev_host_cmd_done;
  assign ev_bits[`SPW_BIT_NV_ERR]    = ev_nv_checksum || save_fail;
  assign ev_bits[`SPW_BIT_PROG_DONE] = ev_prog_done;
  assign ev_bits[`SPW_BIT_CMD_ERR]   = ev_cmd_error || save_fail;
  assign ev_bits[`SPW_BIT_EXIT_MET]  = ev_exit_met;
  assign ev_bits[`SPW_BIT_VOLTAGE]   = ev_voltage;
  assign ev_bits[`SPW_BIT_HOLD_ERR]  = ev_hold_error;
  assign ev_bits[`SPW_BIT_MOVE_ERR]  = ev_move_error;
  assign ev_bits[`SPW_BIT_RX_OVF]    = ev_rx_overflow;
  assign ev_bits[`SPW_BIT_CHECK_MET] = ev_check_met;
  assign ev_bits[`SPW_BIT_TOO_LONG]  = ev_too_long;
  assign ev_bits[`SPW_BIT_FRAMING]   = ev_framing;
  assign ev_bits[`SPW_BIT_KILL]      = kill_rise;
  assign ev_bits[`SPW_BIT_SOFT_LIM]  = ev_soft_limit;
  assign ev_bits[`SPW_BIT_RX_CKS]    = ev_rx_checksum && proto_checksummed;
  assign ev_bits[`SPW_BIT_ABORT_PKT] = ev_aborted_pkt;

  spw_cond_status u_status
  (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .set_bits     (ev_bits),
    .read_strobe  (is_query || is_fixed),
    .clear_strobe (is_clear),
    .clear_mask   (cmd_arg0),
    .live         (live)
  );

  spw_nv_guard u_guard
  (
    .addr         (nv_wr_addr),
    .first_wr     (first_writable),
    .factory_on   (factory_protected),
    .factory_base (FACTORY_BASE),
    .protect_hit  (prot_hit)
  );

  // Reply selection; a command reply wins and a refused store waits for a cycle with no command reply
  wire send_store = !cmd_answer && (store_fail || store_nak_pend);
  wire query_ack  = is_query && (live == 16'h0000);

  wire [1:0] next_resp_kind =
    (pup_busy || pup_bad || send_store) ? spw_pkg::SPW_RESP_NAK :
    ((is_query && !query_ack) || is_fixed) ? spw_pkg::SPW_RESP_WORD :
    spw_pkg::SPW_RESP_ACK;
  wire [7:0] next_resp_cmd  = cmd_answer ? (cmd_has_code ? cmd_code : `SPW_CMD_QUERY)
                                         : `SPW_CMD_STORE;
  wire [7:0] next_nak_code  = pup_busy ? `SPW_NAK_BUSY :
                              ((pup_bad || send_store) ? `SPW_NAK_LOCKOUT : 8'h00);
  wire next_pend = (store_fail && cmd_answer) || (store_nak_pend && cmd_answer);

  // Replies only load output registers, so motion is never disturbed
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      resp_valid    <= 1'b0;
      resp_kind     <= spw_pkg::SPW_RESP_ACK;
      resp_cmd      <= 8'h00;
      resp_word     <= 16'h0000;
      resp_nak_code <= 8'h00;
    end
    else
    begin
      resp_valid    <= cmd_answer || send_store;
      resp_kind     <= next_resp_kind;
      resp_cmd      <= next_resp_cmd;
      resp_word     <= live;
      resp_nak_code <= next_nak_code;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      nv_wr_grant    <= 1'b0;
      nv_wr_denied   <= 1'b0;
      prog_abort     <= 1'b0;
      store_nak_pend <= 1'b0;
      kill_seen      <= 1'b0;
    end
    else
    begin
      nv_wr_grant    <= nv_wr_req && !prot_hit;
      nv_wr_denied   <= wr_blocked;
      prog_abort     <= save_fail;
      store_nak_pend <= next_pend;
      kill_seen      <= kill_active;
    end
  end

  // Protection state
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      first_writable    <= `SPW_FIRST_WR_RST;
      lock_code         <= `SPW_LOCK_RST;
      factory_protected <= FACTORY_PROT_ON;
    end
    else
    begin
      if (pup_set)
      begin
        first_writable <= cmd_arg1;
        lock_code      <= (cmd_arg1 == 16'h0000) ? `SPW_LOCK_RST : cmd_arg0;
      end
      if (pup_ok)
        factory_protected <= 1'b1;
    end
  end

  assign condition_status_word = live;

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_protect_ok;
    is_protect && !device_busy && !pup_bad && !both_zero;
  endsequence

  property p_query_ack;
    is_query && live == 16'h0000 |=> resp_valid && resp_kind == spw_pkg::SPW_RESP_ACK;
  endproperty
  a_query_ack: assert property (p_query_ack) else $error("Empty query not acked");

  property p_query_word;
    is_query && live != 16'h0000 |=> resp_kind == spw_pkg::SPW_RESP_WORD
      && resp_word == $past(live) && resp_cmd == `SPW_CMD_QUERY;
  endproperty
  a_query_word: assert property (p_query_word) else $error("Query word wrong");

  property p_fixed_word;
    is_fixed |=> resp_valid && resp_kind == spw_pkg::SPW_RESP_WORD && resp_word == $past(live);
  endproperty
  a_fixed_word: assert property (p_fixed_word) else $error("Fixed query not a word");

  property p_latch;
    ev_voltage |=> live[`SPW_BIT_VOLTAGE] [*2] or (is_clear ##1 1'b1);
  endproperty
  a_latch: assert property (p_latch) else $error("Status bit did not latch");

  // Clears may land long after the query, so both checks key on the snapshot itself
  sequence s_clear_quiet;
    is_clear && ev_bits == 16'h0000;
  endsequence

  property p_unread_survives;
    is_clear |=> (($past(live) & ~$past(u_status.shown)) & ~live) == 16'h0000;
  endproperty
  a_unread_survives: assert property (p_unread_survives) else $error("Unread bit lost");

  property p_clear_mask;
    s_clear_quiet |=> (live & $past(cmd_arg0) & $past(u_status.shown)) == 16'h0000;
  endproperty
  a_clear_mask: assert property (p_clear_mask) else $error("Masked bits not cleared");

  property p_busy;
    is_protect && device_busy |=> resp_kind == spw_pkg::SPW_RESP_NAK
      && resp_nak_code == `SPW_NAK_BUSY && $stable(first_writable);
  endproperty
  a_busy: assert property (p_busy) else $error("Busy protect not refused");

  property p_bad_lock;
    pup_bad |=> resp_kind == spw_pkg::SPW_RESP_NAK && resp_nak_code == `SPW_NAK_LOCKOUT
      && $stable(first_writable);
  endproperty
  a_bad_lock: assert property (p_bad_lock) else $error("Lockout mismatch accepted");

  property p_protect_set;
    s_protect_ok |=> first_writable == $past(cmd_arg1) && factory_protected;
  endproperty
  a_protect_set: assert property (p_protect_set) else $error("Protect limit not stored");

  property p_unprotect;
    s_protect_ok and cmd_arg1 == 16'h0000 |=> lock_code == 16'h0000 && !prot_on;
  endproperty
  a_unprotect: assert property (p_unprotect) else $error("Unprotect left state");

  property p_block;
    nv_wr_req && first_writable == `SPW_PROT_ALL |=> !nv_wr_grant && nv_wr_denied;
  endproperty
  a_block: assert property (p_block) else $error("Write into locked space granted");

  property p_save_fail;
    save_fail |=> prog_abort && live[`SPW_BIT_NV_ERR] && live[`SPW_BIT_CMD_ERR] && !nv_wr_grant;
  endproperty
  a_save_fail: assert property (p_save_fail) else $error("Blocked save not flagged");

endmodule

// >>> verification/spw_host_model.sv
// Host controller model: sends decoded command packets and collects replies.
// Assumes the block answers within four cycles; idle lines show inverted data.
`timescale 1ns/1ps

module spw_host_model
(
  // Clock
  input  wire logic        ref_clk,
  // Command packet
  output logic             cmd_valid,
  output logic             cmd_has_code,
  output logic [7:0]       cmd_code,
  output logic [15:0]      cmd_arg0,
  output logic [15:0]      cmd_arg1,
  // Reply
  input  wire logic        resp_valid,
  input  wire logic [1:0]  resp_kind,
  input  wire logic [7:0]  resp_cmd,
  input  wire logic [15:0] resp_word,
  input  wire logic [7:0]  resp_nak_code
);
  logic        got;
  logic [1:0]  r_kind;
  logic [7:0]  r_cmd;
  logic [7:0]  r_nak;
  logic [15:0] r_word;

  initial
  begin
    cmd_valid = 1'b0;
    cmd_has_code = 1'b0;
    cmd_code = 8'h00;
    cmd_arg0 = 16'h0000;
    cmd_arg1 = 16'h0000;
  end

  // Waits a bounded time so a silent block cannot hang the host
  task automatic collect();
    got = 1'b0;
    for (int n = 0; n < 4 && !got; n++)
    begin
      if (resp_valid === 1'b1)
      begin
        got = 1'b1;
        r_kind = resp_kind;
        r_cmd = resp_cmd;
        r_word = resp_word;
        r_nak = resp_nak_code;
      end
      else
        @(negedge ref_clk);
    end
  endtask

  // One packet per call; a clear carries its mask in the first argument
  task automatic send(input logic hc, input logic [7:0] c, input logic [15:0] a0,
                      input logic [15:0] a1, input int gap);
    repeat (gap) @(negedge ref_clk);
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd_has_code = hc;
    cmd_code = c;
    cmd_arg0 = a0;
    cmd_arg1 = a1;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    cmd_has_code = ~hc;
    cmd_code = ~c;
    cmd_arg0 = ~a0;
    cmd_arg1 = ~a1;
    collect();
  endtask
endmodule

// >>> verification/tb_top.sv
// Self-checking bench for the status poll and write protect handler.
// Assumes the host model answers via its collect task; inputs move on falling edges.
`timescale 1ns/1ps
`include "spw_params.svh"

module tb_top;
  logic        ref_clk = 1'b0, rst = 1'b1;
  logic        device_busy, kill_active, proto_checksummed, nv_wr_req;
  logic        cmd_valid, cmd_has_code, resp_valid, nv_wr_grant, nv_wr_denied;
  logic        prog_abort, factory_protected, m_fact;
  logic [1:0]  resp_kind, nv_wr_kind;
  logic [7:0]  cmd_code, resp_cmd, resp_nak_code;
  logic [15:0] cmd_arg0, cmd_arg1, resp_word, nv_wr_addr, ev, condition_status_word;
  logic [15:0] first_writable, m_live, m_snap, m_first, m_lock;
  int          n_errors = 0, n_tests = 0;

  always #12.5 ref_clk = ~ref_clk;

  spw_host_model host_u
  (
    .ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_has_code(cmd_has_code),
    .cmd_code(cmd_code), .cmd_arg0(cmd_arg0), .cmd_arg1(cmd_arg1), .resp_valid(resp_valid),
    .resp_kind(resp_kind), .resp_cmd(resp_cmd), .resp_word(resp_word),
    .resp_nak_code(resp_nak_code)
  );

  // Factory protection starts off so that enabling it can be seen
  spw_status_poll #(.FACTORY_PROT_ON(1'b0)) dut_u
  (
    .ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_has_code(cmd_has_code),
    .cmd_code(cmd_code), .cmd_arg0(cmd_arg0), .cmd_arg1(cmd_arg1), .device_busy(device_busy),
    .ev_host_cmd_done(ev[15]), .ev_nv_checksum(ev[14]), .ev_prog_done(ev[13]),
    .ev_cmd_error(ev[12]), .ev_exit_met(ev[11]), .ev_voltage(ev[10]), .ev_hold_error(ev[9]),
    .ev_move_error(ev[8]), .ev_rx_overflow(ev[7]), .ev_check_met(ev[6]), .ev_too_long(ev[5]),
    .ev_framing(ev[4]), .kill_active(kill_active), .ev_soft_limit(ev[2]),
    .ev_rx_checksum(ev[1]), .proto_checksummed(proto_checksummed), .ev_aborted_pkt(ev[0]),
    .nv_wr_req(nv_wr_req), .nv_wr_addr(nv_wr_addr), .nv_wr_kind(nv_wr_kind),
    .resp_valid(resp_valid), .resp_kind(resp_kind), .resp_cmd(resp_cmd),
    .resp_word(resp_word), .resp_nak_code(resp_nak_code), .nv_wr_grant(nv_wr_grant),
    .nv_wr_denied(nv_wr_denied), .prog_abort(prog_abort),
    .condition_status_word(condition_status_word), .first_writable(first_writable),
    .factory_protected(factory_protected)
  );

  task automatic close_out();
    if (n_errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("unexpected %0t %s", $time, msg);
    end
  endtask

  task automatic cmp_resp(input logic [1:0] k, input logic [7:0] c, input logic [15:0] w,
                          input logic [7:0] nk);
    chk(host_u.got === 1'b1 && host_u.r_kind === k && host_u.r_cmd === c, "reply");
    if (k == spw_pkg::SPW_RESP_WORD)
      chk(host_u.r_word === w, "reply word");
    if (k == spw_pkg::SPW_RESP_NAK)
      chk(host_u.r_nak === nk, "refusal code");
  endtask

  task automatic cmp_state();
    chk(condition_status_word === m_live, "status word");
    chk(first_writable === m_first && factory_protected === m_fact, "protect state");
  endtask

  function automatic logic is_prot(input logic [15:0] a);
    return a < m_first || m_first == `SPW_PROT_ALL || (m_fact && a >= `SPW_FACTORY_BASE);
  endfunction

  task automatic fire(input logic [15:0] m);
    @(negedge ref_clk);
    ev = m & 16'hFFF7;
    kill_active = kill_active | m[3];
    @(negedge ref_clk);
    ev = 16'h0000;
    m_live = m_live | (m & (proto_checksummed ? 16'hFFFF : 16'hFFFD));
    cmp_state();
  endtask

  task automatic query(input logic hc, input logic [7:0] c);
    logic [1:0] k;
    k = (c == `SPW_CMD_FIXED || m_live != 16'h0000) ? spw_pkg::SPW_RESP_WORD
                                                     : spw_pkg::SPW_RESP_ACK;
    m_snap = m_live;
    host_u.send(hc, c, 16'h0000, 16'h0000, $urandom % 2);
    cmp_resp(k, c, m_snap, 8'h00);
  endtask

  // Only bits already reported may clear; later ones wait for the next query
  task automatic clr(input logic [15:0] m);
    m_live = m_live & ~(m & m_snap);
    m_snap = m_snap & ~m;
    host_u.send(1'b1, `SPW_CMD_CLEAR, m, 16'h0000, 0);
    cmp_resp(spw_pkg::SPW_RESP_ACK, `SPW_CMD_CLEAR, 16'h0000, 8'h00);
    cmp_state();
  endtask

  task automatic prot(input logic [15:0] a0, input logic [15:0] a1);
    logic [1:0] k;
    logic [7:0] nk;
    k = spw_pkg::SPW_RESP_NAK;
    nk = `SPW_NAK_LOCKOUT;
    if (device_busy)
      nk = `SPW_NAK_BUSY;
    else if (a0 == 16'h0000 && a1 == 16'h0000)
    begin
      k = spw_pkg::SPW_RESP_ACK;
      m_fact = 1'b1;
    end
    else if (m_first == 16'h0000 || a0 == m_lock)
    begin
      k = spw_pkg::SPW_RESP_ACK;
      m_first = a1;
      m_lock = (a1 == 16'h0000) ? 16'h0000 : a0;
      m_fact = 1'b1;
    end
    host_u.send(1'b1, `SPW_CMD_PROTECT, a0, a1, 0);
    cmp_resp(k, `SPW_CMD_PROTECT, 16'h0000, nk);
    cmp_state();
  endtask

  task automatic wr(input logic [15:0] a, input logic [1:0] k);
    logic p;
    p = is_prot(a);
    @(negedge ref_clk);
    nv_wr_req = 1'b1;
    nv_wr_addr = a;
    nv_wr_kind = k;
    @(negedge ref_clk);
    nv_wr_req = 1'b0;
    nv_wr_addr = ~a;
    chk(nv_wr_grant === !p && nv_wr_denied === p, "write verdict");
    chk(prog_abort === (p && k == spw_pkg::SPW_WR_SAVE), "program abort");
    if (p && k == spw_pkg::SPW_WR_SAVE)
      m_live = m_live | 16'h5000;
    if (p && k == spw_pkg::SPW_WR_STORE)
    begin
      host_u.collect();
      cmp_resp(spw_pkg::SPW_RESP_NAK, `SPW_CMD_STORE, 16'h0000, `SPW_NAK_LOCKOUT);
    end
    cmp_state();
  endtask

  initial
  begin
    #100000;
    n_errors++;
    close_out();
  end

  initial
  begin
    void'($urandom(43));
    {device_busy, kill_active, proto_checksummed, nv_wr_req} = 4'h0;
    {nv_wr_addr, nv_wr_kind, ev} = 34'h0;
    {m_live, m_snap, m_first, m_lock, m_fact} = 65'h0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    cmp_state();
    query(1'b1, `SPW_CMD_QUERY);
    query(1'b0, 8'h00);
    query(1'b1, `SPW_CMD_FIXED);
    fire(16'h0002);
    proto_checksummed = 1'b1;
    for (int i = 0; i < 16; i++)
      fire(16'h0001 << i);
    query(1'b1, `SPW_CMD_QUERY);
    clr(16'h00F0);
    query(1'b1, `SPW_CMD_QUERY);
    clr(16'hFFFF);
    kill_active = 1'b0;
    fire(16'h8000);
    query(1'b1, `SPW_CMD_QUERY);
    fire(16'h2000);
    clr(16'hFFFF);
    query(1'b1, `SPW_CMD_FIXED);
    clr(16'hFFFF);
    wr(16'hF900, spw_pkg::SPW_WR_PLAIN);
    device_busy = 1'b1;
    prot(16'd1234, 16'd1000);
    device_busy = 1'b0;
    prot(16'd1234, 16'd1000);
    wr(16'd999, spw_pkg::SPW_WR_SAVE);
    wr(16'd1000, spw_pkg::SPW_WR_SAVE);
    wr(16'd999, spw_pkg::SPW_WR_STORE);
    prot(16'd1, 16'd0);
    prot(16'd0, 16'd0);
    wr(16'hF900, spw_pkg::SPW_WR_PLAIN);
    prot(16'd1234, 16'hFFFF);
    wr(16'hFFFF, spw_pkg::SPW_WR_SAVE);
    prot(16'd1234, 16'd0);
    prot(16'd7, 16'h4000);
    repeat (24)
      wr(16'($urandom), 2'($urandom % 3));
    query(1'b1, `SPW_CMD_QUERY);
    close_out();
  end
endmodule
